// ### hw/apt_ctrl.v
// trigger selection, pending flags and conversion requests for four channel pairs
// assumes trigger inputs are same-clock logic pulses/levels; converter core hands
// back conv_busy and a one-cycle conv_done with the pair index it finished
`timescale 1ns/1ps
`include "apt_defines.vh"
module apt_ctrl (
  sys_clk,
  srst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  glob_swtrg,
  pwm_sev_pri,
  pwm_sev_sec,
  pwm_pri_trg,
  pwm_sec_trg,
  pwm_cl_trg,
  tmr_a_match,
  tmr_b_match,
  conv_busy,
  conv_start,
  conv_pair,
  conv_done,
  done_pair,
  pair_irq,
  irq
);
  input  wire        sys_clk;
  input  wire        srst;
  input  wire [3:0]  reg_addr;
  input  wire [15:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [15:0] reg_rdata;
  input  wire        glob_swtrg;
  input  wire        pwm_sev_pri;
  input  wire        pwm_sev_sec;
  input  wire [7:0]  pwm_pri_trg;
  input  wire [8:0]  pwm_sec_trg;
  input  wire [7:0]  pwm_cl_trg;
  input  wire        tmr_a_match;
  input  wire        tmr_b_match;
  input  wire        conv_busy;
  output reg         conv_start;
  output reg  [1:0]  conv_pair;
  input  wire        conv_done;
  input  wire [1:0]  done_pair;
  output reg  [3:0]  pair_irq;
  output wire        irq;

  // pair slot layout: pair 0,1 in ctrl3 low/high byte, pair 2,3 in ctrl5
  reg  [3:0]  irq_en_q;
  reg  [3:0]  pend_q;
  reg  [3:0]  swtrg_q;
  reg  [4:0]  sel_q [0:3];
  reg  [3:0]  stat_q;
  reg  [3:0]  mask_q;
  reg  [3:0]  inflight_q;
  reg  [30:0] src_prev_q;
  wire [30:0] src_now;
  wire [30:0] src_edge;
  reg  [3:0]  trig_hit;
  wire [3:0]  gnt;
  reg  [3:0]  done_vec;
  wire        wr_c3;
  wire        wr_c5;
  integer     p;

  // flat source vector indexed by selector code minus one
  assign src_now  = {tmr_b_match, pwm_cl_trg, pwm_sec_trg, pwm_sev_sec, tmr_a_match,
                     pwm_pri_trg, pwm_sev_pri, glob_swtrg, 1'b0};
  // levels held high by a source count once only
  assign src_edge = src_now & ~src_prev_q;

  // maps a selector code to the chosen trigger event
  function sel_fire;
    input [4:0]  code;
    input [30:0] ev;
    input        swi;
    begin
      case (code)
        `APT_SEL_OFF: sel_fire = 1'b0;
        `APT_SEL_SWI: sel_fire = swi;
        `APT_SEL_SWG: sel_fire = ev[1];
        `APT_SEL_PSEV: sel_fire = ev[2];
        `APT_SEL_TMRA: sel_fire = ev[11];
        `APT_SEL_SSEV: sel_fire = ev[12];
        `APT_SEL_TMRB: sel_fire = ev[30];
        default:
        begin
          // codes 4..11 -> ev 3..10, 14..22 -> 13..21, 23..30 -> 22..29
          if (code <= `APT_SEL_PRI8)
            sel_fire = ev[code - 5'h01];
          else if (code <= `APT_SEL_SEC9)
            sel_fire = ev[code - 5'h01];
          else
            sel_fire = ev[code - 5'h01];
        end
      endcase
    end
  endfunction

  always @*
  begin
    for (p = 0; p < 4; p = p + 1)
    begin
      // soft trigger waits in its bit until pending may set
      trig_hit[p] = sel_fire(sel_q[p], src_edge, swtrg_q[p]) & ~pend_q[p];
      done_vec[p] = conv_done && (done_pair == p[1:0]);
    end
  end

  // requests wait while the converter is busy
  apt_arb u_arb (
    .req (pend_q & ~inflight_q & {4{~conv_busy & ~conv_start}}),
    .gnt (gnt)
  );

  assign wr_c3 = reg_wr && (reg_addr == `APT_REG_CTRL3);
  assign wr_c5 = reg_wr && (reg_addr == `APT_REG_CTRL5);

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_en_q   <= 4'h0;
      pend_q     <= 4'h0;
      swtrg_q    <= 4'h0;
      stat_q     <= 4'h0;
      mask_q     <= 4'h0;
      inflight_q <= 4'h0;
      src_prev_q <= 31'h0;
      conv_start <= 1'b0;
      conv_pair  <= 2'h0;
      pair_irq   <= 4'h0;
      reg_rdata  <= 16'h0000;
      for (p = 0; p < 4; p = p + 1)
        sel_q[p] <= 5'h00;
    end
    else
    begin
      src_prev_q <= src_now;
      conv_start <= |gnt;
      conv_pair  <= gnt[1] ? 2'h1 : gnt[2] ? 2'h2 : gnt[3] ? 2'h3 : 2'h0;
      for (p = 0; p < 4; p = p + 1)
      begin
        if ((p < 2 && wr_c3) || (p >= 2 && wr_c5))
        begin
          irq_en_q[p] <= reg_wdata[8*(p%2)+`APT_F_IRQEN];
          sel_q[p]    <= reg_wdata[8*(p%2)+`APT_F_SEL_LO +: 5];
        end
        // soft bit: set by write, auto-cleared when pending sets
        if (trig_hit[p])
          swtrg_q[p] <= 1'b0;
        else if ((p < 2 && wr_c3) || (p >= 2 && wr_c5))
          swtrg_q[p] <= reg_wdata[8*(p%2)+`APT_F_SWTRG];
        if (gnt[p])
          inflight_q[p] <= 1'b1;
        else if (done_vec[p])
          inflight_q[p] <= 1'b0;
        if (trig_hit[p])
          pend_q[p] <= 1'b1;
        else if (done_vec[p])
          pend_q[p] <= 1'b0;
        pair_irq[p] <= done_vec[p] & irq_en_q[p];
      end
      if (reg_wr && reg_addr == `APT_REG_MASK)
        mask_q <= reg_wdata[3:0];
      // read clears status, but a new completion in that cycle wins
      stat_q <= ((reg_rd && reg_addr == `APT_REG_STAT) ? 4'h0 : stat_q)
                | (done_vec & irq_en_q);
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `APT_REG_CTRL3: reg_rdata <= {irq_en_q[1], pend_q[1], swtrg_q[1], sel_q[1],
                                        irq_en_q[0], pend_q[0], swtrg_q[0], sel_q[0]};
          `APT_REG_CTRL5: reg_rdata <= {irq_en_q[3], pend_q[3], swtrg_q[3], sel_q[3],
                                        irq_en_q[2], pend_q[2], swtrg_q[2], sel_q[2]};
          `APT_REG_STAT:  reg_rdata <= {12'h000, stat_q};
          `APT_REG_MASK:  reg_rdata <= {12'h000, mask_q};
          default:        reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  assign irq = |(stat_q & mask_q);
endmodule // apt_ctrl

// ### hw/apt_defines.vh
// constants for the paired conversion trigger control block
// included by apt_ctrl.v, not by apt_arb.v; no logic here
`ifndef APT_DEFINES_VH
`define APT_DEFINES_VH
`define APT_NPAIRS      4
`define APT_ADDR_W      4
// register indices (byte address = 4 * index not used: plain port)
`define APT_REG_CTRL3   4'h0
`define APT_REG_CTRL5   4'h1
`define APT_REG_STAT    4'h2
`define APT_REG_MASK    4'h3
// field positions inside one byte-wide pair slot
`define APT_F_IRQEN     7
`define APT_F_PEND      6
`define APT_F_SWTRG     5
`define APT_F_SEL_HI    4
`define APT_F_SEL_LO    0
`define APT_CTRL_RST    16'h0000
// selector codes
`define APT_SEL_OFF     5'h00
`define APT_SEL_SWI     5'h01
`define APT_SEL_SWG     5'h02
`define APT_SEL_PSEV    5'h03
`define APT_SEL_PRI1    5'h04
`define APT_SEL_PRI8    5'h0b
`define APT_SEL_TMRA    5'h0c
`define APT_SEL_SSEV    5'h0d
`define APT_SEL_SEC1    5'h0e
`define APT_SEL_SEC9    5'h16
`define APT_SEL_CL1     5'h17
`define APT_SEL_CL8     5'h1e
`define APT_SEL_TMRB    5'h1f
`endif

// ### hw/apt_arb.v
// fixed priority picker for pending conversion pairs
// combinational; lowest index wins, used by apt_ctrl
`timescale 1ns/1ps
module apt_arb (
  req,
  gnt
);
  input  wire [3:0] req;
  output reg  [3:0] gnt;
  integer i;
  reg     found;
  always @*
  begin
    gnt   = 4'h0;
    found = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (req[i] && !found)
      begin
        gnt[i] = 1'b1;
        found  = 1'b1;
      end
    end
  end
endmodule // apt_arb

// ### tb/apt_core_model.sv
// converter core stand-in: busy from the cycle after a start, then one done pulse
// pair 0 converts slowly (12 cycles) so later requests must wait; others take 2
`timescale 1ns/1ps
module apt_core_model (
  input  logic       sys_clk,
  input  logic       srst,
  input  logic       conv_start,
  input  logic [1:0] conv_pair,
  output logic       conv_busy,
  output logic       conv_done,
  output logic [1:0] done_pair
);
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] pair_q = 2'h0;
  always @(posedge sys_clk)
  begin
    conv_busy <= conv_start || cnt_q > 4'h1;
    conv_done <= cnt_q == 4'h1;
    // pair lines carry junk outside the done pulse
    done_pair <= cnt_q == 4'h1 ? pair_q : ~pair_q;
    pair_q <= conv_start ? conv_pair : pair_q;
    cnt_q <= srst ? 4'h0 : conv_start ? (conv_pair == 2'h0 ? 4'hc : 4'h2) : cnt_q - {3'h0, |cnt_q};
  end
endmodule // apt_core_model

// ### tb/apt_ctrl_asserts.sv
// port-level checks for apt_ctrl
// bound into apt_ctrl; one clock, synchronous reset
`timescale 1ns/1ps
module apt_ctrl_asserts (
  input logic        sys_clk,
  input logic        srst,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        conv_busy,
  input logic        conv_start,
  input logic        conv_done,
  input logic [1:0]  done_pair,
  input logic [3:0]  pair_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_quiet2; !conv_start [*2]; endsequence
  a_start_free: assert property (conv_start |-> !$past(conv_busy)) else $error("busy start");
  a_busy_hold: assert property (conv_busy |=> !conv_start) else $error("start in busy");
  a_start_gap: assert property (conv_start |=> s_quiet2) else $error("starts too close");
  a_irq_cause: assert property (|pair_irq |-> $past(conv_done)) else $error("stray irq");
  a_irq_pair: assert property (|pair_irq |-> pair_irq == (4'h1 << $past(done_pair)))
    else $error("irq on wrong pair");
  a_irq_pulse: assert property (|pair_irq |=> pair_irq == 4'h0) else $error("irq too long");
  a_rdata_gate: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0) else $error("stray data");
  a_reset_quiet: assert property ($past(srst) |-> !conv_start && pair_irq == 4'h0)
    else $error("output after reset");
endmodule // apt_ctrl_asserts
bind apt_ctrl apt_ctrl_asserts u_apt_ctrl_asserts (.*);

// ### tb/apt_ctrl_bench.sv
// self-checking bench for apt_ctrl
// apt_core_model stands in for the converter core
`timescale 1ns/1ps
module apt_ctrl_bench;
  logic        sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd1 = 1'b0;
  logic        conv_busy, conv_start, conv_done, irq;
  logic [3:0]  reg_addr = 4'h0, pair_irq;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, rdq[$];
  logic [31:0] src = 32'h0;
  logic [1:0]  conv_pair, done_pair, pq[$];
  int          mismatches = 0, n_checks = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  apt_ctrl u_apt_ctrl (.*, .glob_swtrg(src[2]), .pwm_sev_pri(src[3]), .pwm_pri_trg(src[11:4]),
    .tmr_a_match(src[12]), .pwm_sev_sec(src[13]), .pwm_sec_trg(src[22:14]),
    .pwm_cl_trg(src[30:23]), .tmr_b_match(src[31]));
  apt_core_model u_apt_core_model (.*);
  task chk(input logic ok);
    n_checks++;
    mismatches += (ok !== 1'b1);
    if (ok !== 1'b1)
      $display("ERROR %0t mismatch", $time);
  endtask
  task give_verdict;
    mismatches += (cyc >= 6000);
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus(input logic [3:0] a, input logic [15:0] d, input logic r);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, !r, r};
    if (r)
      rdq.push_back(d);
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (rd1)
      chk(reg_rdata === rdq.pop_front());
    if (|pair_irq)
      chk(pair_irq === 4'h1);
    if (conv_start === 1'b1)
      chk(pq.size() > 0 && conv_pair === pq.pop_front());
    rd1 <= reg_rd;
    if (cyc == 6000)
      give_verdict;
  end
  initial
  begin
    void'($urandom(32'h86d0));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    bus(4'h1, 16'h0000, 1'b1);
    bus(4'h7, 16'hffff, 1'b0);
    bus(4'h7, 16'h0000, 1'b1);
    bus(4'h3, 16'h0001, 1'b0);
    for (int c = 0; c < 32; c++)
    begin
      if (c != 0)
        pq.push_back(2'h0);
      bus(4'h0, {11'h004, c[4:0]}, 1'b0);
      src <= c == 0 ? ($urandom() | 32'h4) & 32'hffff_fffc : 32'h1 << c;
      if (c == 1)
        bus(4'h0, 16'h00a1, 1'b0);
      repeat ($urandom_range(3, 1)) @(posedge sys_clk);
      src <= 32'h0;
      repeat (20) @(posedge sys_clk);
      chk(irq === (c != 0));
      bus(4'h2, {15'h0, c != 0}, 1'b1);
    end
    $display("trigger codes done");
    pq = {2'h0, 2'h1, 2'h2, 2'h3};
    bus(4'h0, 16'h1f0c, 1'b0);
    bus(4'h1, 16'h0102, 1'b0);
    src <= 32'h8000_1004;
    @(posedge sys_clk);
    src <= 32'h0;
    bus(4'h1, 16'h2102, 1'b0);
    repeat (2) @(posedge sys_clk);
    bus(4'h1, 16'h4142, 1'b1);
    repeat (60) @(posedge sys_clk);
    bus(4'h2, 16'h0000, 1'b1);
    chk(pq.size() == 0);
    $display("priority done");
    give_verdict;
  end
endmodule // apt_ctrl_bench
